/* inc/mcrq_pkg.sv */
// Types for the command request port
package mcrq_pkg;
   typedef enum logic [2:0] {
      MCRQ_WRITE = 3'b001,
      MCRQ_READ  = 3'b010,
      MCRQ_NOOP  = 3'b100
   } mcrq_op_e;
   typedef logic [1:0] mcrq_opcode_t;
endpackage

/* inc/mcrq_regs.svh */
// Constants for the command request port
`ifndef MCRQ_REGS_SVH
`define MCRQ_REGS_SVH
`define MCRQ_OP_WRITE      2'h0
`define MCRQ_OP_READ       2'h1
`define MCRQ_OP_NO_OPERATION_A 2'h2
`define MCRQ_OP_NO_OPERATION_B 2'h3
`define MCRQ_OP_WIDTH      2
`define MCRQ_SLOTS_DEF     2
`define MCRQ_ADDR_W_DEF    20
`define MCRQ_BANK_W_DEF    4
`define MCRQ_QDEPTH_DEF    8
`define MCRQ_CNT_ONE       4'h1
`define MCRQ_CNT_ZERO      4'h0
`endif

/* rtl/mcrq_port.sv */
// Command request port of a reduced-latency memory controller user interface
`timescale 1ns/1ps
`include "mcrq_regs.svh"

module mcrq_port #(
   parameter int SLOTS  = `MCRQ_SLOTS_DEF,
   parameter int ADDR_W = `MCRQ_ADDR_W_DEF,
   parameter int BANK_W = `MCRQ_BANK_W_DEF,
   parameter int QDEPTH = `MCRQ_QDEPTH_DEF
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          clk_en,
   input  wire logic                          calib_done_in,
   input  wire logic                          req_strobe,
   input  wire logic [`MCRQ_OP_WIDTH*SLOTS-1:0] req_opcode,
   input  wire logic [ADDR_W*SLOTS-1:0]       req_addr,
   input  wire logic [BANK_W*SLOTS-1:0]       req_bank,
   input  wire logic                          exec_ready,
   output logic                               training_done,
   output logic                               queue_full,
   output logic                               queue_empty,
   output logic                               exec_valid,
   output logic                               exec_is_read,
   output logic [ADDR_W-1:0]                  exec_addr,
   output logic [BANK_W-1:0]                  exec_bank
);
   import mcrq_pkg::*;

   localparam int CW = $clog2(QDEPTH + 1);
   localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
   localparam int EW = 1 + ADDR_W + BANK_W;

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      logic [QDEPTH-1:0][EW-1:0] mem;
      logic [PW-1:0]             wp;
      logic [PW-1:0]             rp;
      logic [CW-1:0]             cnt;
      logic                      done;
      logic                      full;
      logic                      empty;
      logic                      ov;
      logic                      rd;
      logic [ADDR_W-1:0]         ad;
      logic [BANK_W-1:0]         bk;
   } mcrq_state_s;

   mcrq_state_s   st_q;
   mcrq_state_s   st_d;
   // Live slot count of the present cycle, also watched by the checks
   logic [CW-1:0] live_c;

   // --------------------------------------------------------------
   // Opcode decode
   // --------------------------------------------------------------
   // Codes 10 and 11 both fall to no_operation
   function automatic mcrq_op_e mcrq_decode(input mcrq_opcode_t op);
      case (op)
         `MCRQ_OP_WRITE: mcrq_decode = MCRQ_WRITE;
         `MCRQ_OP_READ:  mcrq_decode = MCRQ_READ;
         default:        mcrq_decode = MCRQ_NOOP;
      endcase
   endfunction

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   // All live slots of one user cycle enter the queue together, so a
   // request is taken only when room exists for every one of them.
   // A partial accept would split the cycle and leave the requester
   // no way to learn which slots were lost; the whole cycle is refused.
   // Room is judged before this cycle's drain, which costs one entry of
   // headroom but keeps the accept path short.
   always_comb begin
      logic [CW-1:0] live;
      logic [CW-1:0] cnt_n;
      logic [PW-1:0] wp_n;
      logic          take;
      logic          pop;
      mcrq_op_e      op;
      live  = '0;
      cnt_n = '0;
      wp_n  = '0;
      take  = 1'b0;
      pop   = 1'b0;
      op    = MCRQ_NOOP;
      st_d  = st_q;
      st_d.done = calib_done_in;
      for (int i = 0; i < SLOTS; i++) begin
         op = mcrq_decode(req_opcode[i*`MCRQ_OP_WIDTH +: `MCRQ_OP_WIDTH]);
         if (op != MCRQ_NOOP)
            live = live + CW'(1);
      end
      pop  = st_q.ov && exec_ready;
      cnt_n = st_q.cnt - (((!st_q.empty) && (!st_q.ov || pop)) ? CW'(1) : CW'(0));
      // Strobe low or queue full: nothing queued
      take = req_strobe && !st_q.full && st_q.done
             && (CW'(QDEPTH) - st_q.cnt >= live);
      // Drain head into output register
      if (!st_q.ov || pop) begin
         st_d.ov = !st_q.empty;
         if (!st_q.empty) begin
            {st_d.rd, st_d.ad, st_d.bk} = st_q.mem[st_q.rp];
            st_d.rp = (st_q.rp == PW'(QDEPTH - 1)) ? '0 : st_q.rp + PW'(1);
         end
      end
      wp_n = st_q.wp;
      if (take) begin
         for (int i = 0; i < SLOTS; i++) begin
            op = mcrq_decode(req_opcode[i*`MCRQ_OP_WIDTH +: `MCRQ_OP_WIDTH]);
            if (op != MCRQ_NOOP) begin
               st_d.mem[wp_n] = {op == MCRQ_READ,
                                 req_addr[i*ADDR_W +: ADDR_W],
                                 req_bank[i*BANK_W +: BANK_W]};
               wp_n = (wp_n == PW'(QDEPTH - 1)) ? '0 : wp_n + PW'(1);
            end
         end
         cnt_n = cnt_n + live;
      end
      st_d.wp    = wp_n;
      st_d.cnt   = cnt_n;
      st_d.full  = (cnt_n == CW'(QDEPTH));
      st_d.empty = (cnt_n == '0);
      live_c     = live;
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Empty is the only flag that resets high
         st_q       <= '0;
         st_q.empty <= 1'b1;
      // Clock enable low freezes every field, flags included
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // --------------------------------------------------------------
   // Outputs, each straight from a state flop
   // --------------------------------------------------------------
   assign training_done = st_q.done;
   assign queue_full    = st_q.full;
   assign queue_empty   = st_q.empty;
   assign exec_valid    = st_q.ov;
   assign exec_is_read  = st_q.rd;
   assign exec_addr     = st_q.ad;
   assign exec_bank     = st_q.bk;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   AST_FULL_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && st_q.full) |=> st_q.cnt <= $past(st_q.cnt))
      else $error("Queue grew while full");
   AST_IDLE_NO_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && !req_strobe) |=> st_q.wp == $past(st_q.wp))
      else $error("Write pointer moved without strobe");
   AST_NOOP_DISCARD: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && req_strobe && live_c == '0) |=> st_q.wp == $past(st_q.wp))
      else $error("No-operation slots were queued");
   AST_DONE_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en |=> training_done == $past(calib_done_in))
      else $error("Training-done does not follow calibration");
   AST_FULL_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (queue_full == (st_q.cnt == CW'(QDEPTH))) && (!queue_full || st_q.wp == st_q.rp))
      else $error("Full flag disagrees with level");
   AST_NO_TRAIN_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && !st_q.done) |=> st_q.wp == $past(st_q.wp))
      else $error("Queued before training done");
   AST_WRITE_TYPE: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && st_q.empty && !st_q.ov && st_q.done && req_strobe
       && req_opcode[1:0] == `MCRQ_OP_WRITE) ##1 clk_en
      |=> exec_valid && !exec_is_read && exec_addr == $past(req_addr[ADDR_W-1:0], 2)
       && exec_bank == $past(req_bank[BANK_W-1:0], 2))
      else $error("Write slot did not reach output as a write");
   AST_READ_OUT: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && st_q.empty && !st_q.ov && st_q.done && req_strobe
       && req_opcode[1:0] == `MCRQ_OP_READ) ##1 clk_en
      |=> exec_valid && exec_is_read && exec_addr == $past(req_addr[ADDR_W-1:0], 2))
      else $error("Read slot did not reach output");
   AST_EXEC_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      (exec_valid && !(clk_en && exec_ready))
      |=> exec_valid && $stable(exec_is_read) && $stable(exec_addr) && $stable(exec_bank))
      else $error("Head command changed before it was taken");
   AST_ROOM_REFUSE: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && req_strobe && (CW'(QDEPTH) - st_q.cnt < live_c))
      |=> st_q.wp == $past(st_q.wp))
      else $error("Queued a cycle that did not fit");
   AST_EMPTY_OUT: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && queue_empty && !exec_valid && !req_strobe)
      |=> !exec_valid)
      else $error("Command appeared without a request");
   AST_LIVE_TAKEN: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && req_strobe && st_q.done && st_q.empty && !st_q.ov && live_c != '0)
      |=> !queue_empty)
      else $error("Live slots were not queued");

   // --------------------------------------------------------------
   // Coverage
   // --------------------------------------------------------------
   COV_FULL: cover property (@(posedge sys_clk) queue_full);
   COV_EXEC: cover property (@(posedge sys_clk) exec_valid && exec_ready);
   COV_NOOP: cover property (@(posedge sys_clk) req_strobe && req_opcode[1]);
   COV_WRITE: cover property (@(posedge sys_clk) exec_valid && exec_ready && !exec_is_read);
   COV_ROOM_REFUSE: cover property (@(posedge sys_clk) clk_en && req_strobe && st_q.done && !st_q.full
      && (CW'(QDEPTH) - st_q.cnt < live_c));
endmodule // mcrq_port

/* sim/mcrq_port_tb.sv */
// Self-checking bench for the command request port
`timescale 1ns/1ps
module mcrq_port_tb;
   localparam int S = 2;
   logic sys_clk = 0, rst = 1, clk_en = 1, calib = 0, go = 0, obey = 1, rdy = 0;
   logic [2*S-1:0] op = '0, req_opcode;
   logic [20*S-1:0] ad = '0, req_addr;
   logic [4*S-1:0] bk = '0, req_bank;
   logic req_strobe, training_done, queue_full, queue_empty, exec_valid, exec_is_read;
   logic [19:0] exec_addr;
   logic [3:0] exec_bank;
   logic [1:0] rmode = 2'h0;
   logic [31:0] lfsr = 32'h52ae;
   logic [24:0] expq[$];
   int failures = 0, samples_checked = 0;
   int occ, live;
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input logic g, input logic [2*S-1:0] o);
      @(posedge sys_clk);
      #1;
      lfsr = lfsr_next(lfsr);
      go = g;
      op = o;
      ad = {lfsr[19:0], lfsr[31:12]};
      bk = lfsr[7:0];
      rdy = rmode[1] ? lfsr[3] : rmode[0];
      clk_en = rmode[1] ? (lfsr[6] | lfsr[7]) : 1'b1;
   endtask
   initial forever #5 sys_clk = ~sys_clk;
   initial begin
      #50000;
      failures++;
      final_report();
   end
   mcrq_requester #(.SLOTS(S), .ADDR_W(20), .BANK_W(4)) requester (.go(go), .obey(obey),
      .training_done(training_done), .queue_full(queue_full), .op(op), .addr(ad), .bank(bk),
      .req_strobe(req_strobe), .req_opcode(req_opcode), .req_addr(req_addr), .req_bank(req_bank));
   mcrq_port #(.SLOTS(S), .ADDR_W(20), .BANK_W(4), .QDEPTH(8)) dut (.sys_clk(sys_clk), .rst(rst),
      .clk_en(clk_en), .calib_done_in(calib), .req_strobe(req_strobe), .req_opcode(req_opcode),
      .req_addr(req_addr), .req_bank(req_bank), .exec_ready(rdy), .training_done(training_done),
      .queue_full(queue_full), .queue_empty(queue_empty), .exec_valid(exec_valid),
      .exec_is_read(exec_is_read), .exec_addr(exec_addr), .exec_bank(exec_bank));
   // Reference: a cycle is taken whole only if all its live slots fit;
   // live slots queued slot 0 first, popped on ready
   always @(posedge sys_clk) if (!rst && clk_en) begin
      occ = expq.size() - (exec_valid ? 1 : 0);
      live = 0;
      for (int i = 0; i < S; i++) if (!req_opcode[2*i+1]) live++;
      if (req_strobe && training_done && !queue_full && (8 - occ >= live))
         for (int i = 0; i < S; i++) if (!req_opcode[2*i+1])
            expq.push_back({req_opcode[2*i], req_addr[20*i+:20], req_bank[4*i+:4]});
      if (exec_valid && rdy) begin
         if (expq.size() == 0) check("spurious", 1, 0);
         else check("head", {exec_is_read, exec_addr, exec_bank}, expq.pop_front());
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst = 0;
      obey = 0;
      repeat (4) cyc(1, 4'h5);
      repeat (3) cyc(0, 4'h4);
      check("exec_valid", exec_valid, 0);
      $display("untrained test done");
      calib = 1;
      obey = 1;
      rmode = 2'h1;
      repeat (2) cyc(0, 4'h0);
      check("training_done", training_done, 1);
      for (int c = 0; c < 16; c++) cyc(1, c[3:0]);
      repeat (8) cyc(0, 4'h0);
      check("drained", expq.size(), 0);
      $display("opcode test done");
      rmode = 2'h0;
      repeat (8) cyc(1, 4'h9);
      // Seven stored and one at the output: a two-slot cycle no longer fits
      cyc(1, 4'h5);
      cyc(1, 4'h9);
      check("room_refused", expq.size(), 8);
      check("queue_full", queue_full, 0);
      obey = 0;
      cyc(1, 4'h0);
      cyc(0, 4'h0);
      check("queue_full", queue_full, 1);
      check("full_refused", expq.size(), 9);
      obey = 1;
      rmode = 2'h1;
      repeat (20) cyc(0, 4'h0);
      check("queue_empty", queue_empty, 1);
      check("drained", expq.size(), 0);
      $display("full test done");
      rmode = 2'h2;
      repeat (300) cyc(lfsr[0], {lfsr[5:4], lfsr[9:8]});
      rmode = 2'h1;
      repeat (20) cyc(0, 4'h0);
      check("drained", expq.size(), 0);
      $display("random test done");
      final_report();
   end
endmodule // mcrq_port_tb

/* sim/mcrq_requester.sv */
// Requester model: user logic issuing commands to the port
`timescale 1ns/1ps
module mcrq_requester #(
   parameter int SLOTS  = 2,
   parameter int ADDR_W = 20,
   parameter int BANK_W = 4
) (
   input  wire logic                    go,
   input  wire logic                    obey,
   input  wire logic                    training_done,
   input  wire logic                    queue_full,
   input  wire logic [2*SLOTS-1:0]      op,
   input  wire logic [ADDR_W*SLOTS-1:0] addr,
   input  wire logic [BANK_W*SLOTS-1:0] bank,
   output logic                         req_strobe,
   output logic [2*SLOTS-1:0]           req_opcode,
   output logic [ADDR_W*SLOTS-1:0]      req_addr,
   output logic [BANK_W*SLOTS-1:0]      req_bank
);
   // Rudeness only when a refusal scenario asks for it
   assign req_strobe = go & (~obey | (training_done & ~queue_full));
   // Single slot cannot take no_operation, so fold it to a real command
   assign req_opcode = op & ~((SLOTS > 1) ? '0 : {SLOTS{2'b10}});
   // Idle lines scrambled so a stale copy never looks valid
   assign req_addr   = req_strobe ? addr : ~addr;
   assign req_bank   = req_strobe ? bank : ~bank;
endmodule // mcrq_requester
